// ===== hdl/ppc_pad.sv
// one pad: pull-up gating and drive mode
`timescale 1ns/1ns
module ppc_pad (
  input wire logic pu_bit,
  input wire logic pu_global_off,
  input wire logic is_output,
  input wire logic pu_force,
  input wire logic sink_only,
  input wire logic out_val,
  output logic pu_on,
  output logic pad_out,
  output logic pad_oe
);
  // ****************************************
  // pad logic
  // ****************************************
  always_comb begin
    // an output pin keeps its pull-up only when pu_force is set
    pu_on = (pu_bit & ~pu_global_off & ~is_output) | pu_force;
    pad_out = out_val;
    // sink-only never drives high
    pad_oe = is_output & ~(sink_only & out_val);
  end
endmodule

// ===== hdl/ppc_pkg.sv
// constants for the port pad control block
package ppc_pkg;
  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [3:0] PPC_ADDR_PA_PU = 4'h0;
  localparam logic [3:0] PPC_ADDR_PA_OD = 4'h4;
  localparam logic [3:0] PPC_ADDR_PB_PU = 4'h8;
  localparam logic [3:0] PPC_ADDR_PB_OD = 4'hC;
  // ****************************************
  // implemented bits and reset values
  // ****************************************
  localparam logic [7:0] PPC_PA_PU_MASK = 8'h3F;
  localparam logic [7:0] PPC_PA_OD_MASK = 8'h37;
  localparam logic [7:0] PPC_PB_PU_MASK = 8'hF0;
  localparam logic [7:0] PPC_PB_OD_MASK = 8'hF0;
  localparam logic [7:0] PPC_PA_PU_RST = 8'h3F;
  localparam logic [7:0] PPC_PB_PU_RST = 8'hF0;
  localparam logic [7:0] PPC_OD_RST = 8'h00;
  localparam int PPC_RESET_PIN = 3;
endpackage

// ===== hdl/ppc_top.sv
// port pad control: pull-ups, sink-only drive and third-port output select
//
// Summary of operation
// - first port pins 5..0 each have a pull-up enable bit, one enables
// - second port pins 7..4 each have a pull-up enable bit, one enables
// - global pull-up disable set forces every pull-up off except the forced first port pin 3 pull-up
// - a pin configured as output has its pull-up on only as the forced first port pin 3
// - external reset enabled forces first port pin 3 pull-up, not readable
// - first port pins 5,4,2,1,0 sink-only bit: one means never drive high
// - sink-only bit zero gives normal push-pull drive
// - second port pins 7..4 sink-only bits with same encoding
// - unimplemented register bits ignore writes and read zero
// - reset sets pull-up bits to one and sink-only bits to zero
// - after reset third port pins drive their output latch
// - other third port digital functions come only from the pin router
// - analog inputs on third port active only when analog select set
// - routed digital outputs keep driving a pin in analog mode
`timescale 1ns/1ns
module ppc_top (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // global controls
  input wire logic GLOBAL_PULLUP_DISABLE_N,
  input wire logic EXT_RESET_PIN_ENABLE,
  // first and second port
  input wire logic [7:0] PORTA_DIR_OUT,
  input wire logic [7:0] PORTA_LATCH,
  input wire logic [7:0] PORTB_DIR_OUT,
  input wire logic [7:0] PORTB_LATCH,
  output logic [7:0] FIRST_PORT_PINS_OUT,
  output logic [7:0] FIRST_PORT_PINS_OE,
  output logic [7:0] FIRST_PORT_PULLUP,
  output logic [7:0] SECOND_PORT_PINS_OUT,
  output logic [7:0] SECOND_PORT_PINS_OE,
  output logic [7:0] SECOND_PORT_PULLUP,
  // third port
  input wire logic [7:0] PORTC_LATCH,
  input wire logic [7:0] PORTC_DIR_OUT,
  input wire logic [7:0] PORTC_ANALOG_SELECT,
  input wire logic [7:0] PERIPHERAL_PIN_ROUTER_SEL,
  input wire logic [7:0] PERIPHERAL_PIN_ROUTER_OUT,
  input wire logic [7:0] PORTC_PINS_IN,
  output logic [7:0] PORTC_PINS_OUT,
  output logic [7:0] PORTC_PINS_OE,
  output logic [7:0] PORTC_DIGITAL_IN,
  output logic [7:0] PORTC_ANALOG_ACTIVE
);
  import ppc_pkg::*;

  typedef struct packed {
    logic [7:0] porta_pullup_bits;
    logic [7:0] porta_sink_only_ctl;
    logic [7:0] portb_pullup_bits;
    logic [7:0] portb_sink_only_ctl;
    logic [31:0] rdata;
    logic ack;
    logic [7:0] pc_out;
  } ppc_state_t;

  ppc_state_t state;
  ppc_state_t next_state;
  logic [7:0] wbyte;
  logic [7:0] pa_pu_on;
  logic [7:0] pb_pu_on;
  logic [7:0] pa_force;
  logic global_off;
  logic req;

  // ****************************************
  // bus slave and registers
  // ****************************************
  // one wait state on every access; read data come from a flop
  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~state.ack;
  assign AVS_READDATA = state.rdata;
  assign wbyte = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : 8'h00;
  assign global_off = GLOBAL_PULLUP_DISABLE_N;

  always_comb begin
    next_state = state;
    next_state.ack = req & ~state.ack;
    if (AVS_WRITE && !state.ack && AVS_BYTEENABLE[0]) begin
      case (AVS_ADDRESS)
        // masks drop writes to missing bits
        PPC_ADDR_PA_PU: next_state.porta_pullup_bits = wbyte & PPC_PA_PU_MASK;
        PPC_ADDR_PA_OD: next_state.porta_sink_only_ctl = wbyte & PPC_PA_OD_MASK;
        PPC_ADDR_PB_PU: next_state.portb_pullup_bits = wbyte & PPC_PB_PU_MASK;
        PPC_ADDR_PB_OD: next_state.portb_sink_only_ctl = wbyte & PPC_PB_OD_MASK;
        default: next_state.rdata = state.rdata;
      endcase
    end
    if (AVS_READ && !state.ack) begin
      case (AVS_ADDRESS)
        // override on pin three is not reflected here
        PPC_ADDR_PA_PU: next_state.rdata = {24'h000000, state.porta_pullup_bits};
        PPC_ADDR_PA_OD: next_state.rdata = {24'h000000, state.porta_sink_only_ctl};
        PPC_ADDR_PB_PU: next_state.rdata = {24'h000000, state.portb_pullup_bits};
        PPC_ADDR_PB_OD: next_state.rdata = {24'h000000, state.portb_sink_only_ctl};
        default: next_state.rdata = 32'h00000000;
      endcase
    end
    // ****************************************
    // third port output select
    // ****************************************
    // router output wins, even in analog mode
    next_state.pc_out = (PERIPHERAL_PIN_ROUTER_SEL & PERIPHERAL_PIN_ROUTER_OUT)
      | (~PERIPHERAL_PIN_ROUTER_SEL & PORTC_LATCH);
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      next_state_reset();
    end else begin
      state <= next_state;
    end
  end

  task automatic next_state_reset();
    state.porta_pullup_bits <= PPC_PA_PU_RST;
    state.porta_sink_only_ctl <= PPC_OD_RST;
    state.portb_pullup_bits <= PPC_PB_PU_RST;
    state.portb_sink_only_ctl <= PPC_OD_RST;
    state.rdata <= 32'h00000000;
    state.ack <= 1'b0;
    state.pc_out <= 8'h00;
  endtask

  // ****************************************
  // pads of the first two ports
  // ****************************************
  always_comb begin
    pa_force = 8'h00;
    // reset pin keeps its pull-up whatever the bits say
    pa_force[PPC_RESET_PIN] = EXT_RESET_PIN_ENABLE;
  end

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pad
      ppc_pad u_pa (
        .pu_bit(state.porta_pullup_bits[i]),
        .pu_global_off(global_off),
        .is_output(PORTA_DIR_OUT[i]),
        .pu_force(pa_force[i]),
        .sink_only(state.porta_sink_only_ctl[i]),
        .out_val(PORTA_LATCH[i]),
        .pu_on(pa_pu_on[i]),
        .pad_out(FIRST_PORT_PINS_OUT[i]),
        .pad_oe(FIRST_PORT_PINS_OE[i])
      );
      ppc_pad u_pb (
        .pu_bit(state.portb_pullup_bits[i]),
        .pu_global_off(global_off),
        .is_output(PORTB_DIR_OUT[i]),
        .pu_force(1'b0),
        .sink_only(state.portb_sink_only_ctl[i]),
        .out_val(PORTB_LATCH[i]),
        .pu_on(pb_pu_on[i]),
        .pad_out(SECOND_PORT_PINS_OUT[i]),
        .pad_oe(SECOND_PORT_PINS_OE[i])
      );
    end
  endgenerate

  assign FIRST_PORT_PULLUP = pa_pu_on;
  assign SECOND_PORT_PULLUP = pb_pu_on;
  assign PORTC_PINS_OUT = state.pc_out;
  assign PORTC_PINS_OE = PORTC_DIR_OUT | PERIPHERAL_PIN_ROUTER_SEL;
  // analog pins read zero digitally
  assign PORTC_ANALOG_ACTIVE = PORTC_ANALOG_SELECT;
  assign PORTC_DIGITAL_IN = PORTC_PINS_IN & ~PORTC_ANALOG_SELECT;

  // ****************************************
  // checks
  // ****************************************
  a_global_pu_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    global_off |-> (SECOND_PORT_PULLUP == 8'h00))
    else $error("pull-up on while globally disabled");
  a_output_pu_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    PORTA_DIR_OUT[0] |-> !FIRST_PORT_PULLUP[0])
    else $error("pull-up on an output pin");
  a_reset_pin_pu: assert property (@(posedge SYS_CLK) disable iff (RST)
    EXT_RESET_PIN_ENABLE |-> FIRST_PORT_PULLUP[3])
    else $error("reset pin pull-up missing");
  a_sink_only_drive: assert property (@(posedge SYS_CLK) disable iff (RST)
    (state.porta_sink_only_ctl[0] && PORTA_LATCH[0]) |-> !FIRST_PORT_PINS_OE[0])
    else $error("sink-only pin driven high");
  a_push_pull_drive: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!state.portb_sink_only_ctl[4] && PORTB_DIR_OUT[4]) |-> SECOND_PORT_PINS_OE[4])
    else $error("push-pull pin not driven");
  a_unimpl_zero: assert property (@(posedge SYS_CLK) disable iff (RST)
    (state.porta_sink_only_ctl[7:6] == 2'b00) && !state.porta_sink_only_ctl[3])
    else $error("unimplemented bit set");
  a_reset_values: assert property (@(posedge SYS_CLK)
    $past(RST) |-> (state.porta_pullup_bits == 8'h3F && state.portb_sink_only_ctl == 8'h00))
    else $error("wrong value after reset");
  a_latch_default: assert property (@(posedge SYS_CLK) disable iff (RST)
    (PERIPHERAL_PIN_ROUTER_SEL[0] == 1'b0) ##1 (!$past(RST))
      |-> PORTC_PINS_OUT[0] == $past(PORTC_LATCH[0]))
    else $error("third port latch not driven");
  a_write_taken: assert property (@(posedge SYS_CLK) disable iff (RST)
    (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == PPC_ADDR_PB_PU && AVS_BYTEENABLE[0])
      |=> state.portb_pullup_bits == ($past(AVS_WRITEDATA[7:0]) & 8'hF0))
    else $error("pull-up write lost");
endmodule

// ===== test/ppc_ext_model.sv
// pad-side circuitry model: resolves pin levels from drive and pull-up
`timescale 1ns/1ns
module ppc_ext_model (
  // pad side of the device
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pu,
  // resolved pin levels
  output logic [7:0] level
);
  // ********
  // pin resolution
  // ********
  // a floating pin shows the inverse, so a stale value never passes
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level[i] = pad_oe[i] ? pad_out[i] : (pad_pu[i] ? 1'b1 : ~pad_out[i]);
    end
  end
endmodule

// ===== test/tb.sv
// self-checking bench for the port pad control block
`timescale 1ns/1ns
module tb;
  import ppc_pkg::*;
  logic clk = 0, rst = 1, rd = 0, wr = 0, gdis = 0, extr = 0, wq_n = 1, wq;
  logic [3:0] adr = 0, be = 4'hF;
  logic [31:0] wd = 0, rdat, v, w, x;
  logic [7:0] da = 0, la = 0, db = 0, lb = 0, lc = 0, dc = 0, an = 0, rs = 0, ro = 0;
  logic [7:0] oa, ea, pa, ob, eb, pb, pin_c, oc, ec, dic, aac, xa, xc, ee;
  logic [7:0] r [4];
  logic [7:0] exq [$];
  int n_fail = 0, tests_run = 0, cyc = 0;
  logic [3:0] ad [4] = '{PPC_ADDR_PA_PU, PPC_ADDR_PA_OD, PPC_ADDR_PB_PU, PPC_ADDR_PB_OD};
  logic [7:0] mk [4] = '{PPC_PA_PU_MASK, PPC_PA_OD_MASK, PPC_PB_PU_MASK, PPC_PB_OD_MASK};

  ppc_top ppc_top_inst (.SYS_CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wq), .GLOBAL_PULLUP_DISABLE_N(gdis), .EXT_RESET_PIN_ENABLE(extr),
    .PORTA_DIR_OUT(da), .PORTA_LATCH(la), .PORTB_DIR_OUT(db), .PORTB_LATCH(lb),
    .FIRST_PORT_PINS_OUT(oa), .FIRST_PORT_PINS_OE(ea), .FIRST_PORT_PULLUP(pa),
    .SECOND_PORT_PINS_OUT(ob), .SECOND_PORT_PINS_OE(eb), .SECOND_PORT_PULLUP(pb),
    .PORTC_LATCH(lc), .PORTC_DIR_OUT(dc), .PORTC_ANALOG_SELECT(an),
    .PERIPHERAL_PIN_ROUTER_SEL(rs), .PERIPHERAL_PIN_ROUTER_OUT(ro), .PORTC_PINS_IN(pin_c),
    .PORTC_PINS_OUT(oc), .PORTC_PINS_OE(ec), .PORTC_DIGITAL_IN(dic),
    .PORTC_ANALOG_ACTIVE(aac));
  ppc_ext_model ppc_ext_model_inst (.pad_out(oc), .pad_oe(ec), .pad_pu(8'h00), .level(pin_c));

  // ********
  // shared tasks
  // ********
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // reads carry their expected byte in d
  task automatic bus(input logic wn, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wr <= wn;
    rd <= !wn;
    wd <= {24'h0, d};
    if (!wn) exq.push_back(d);
    do @(posedge clk); while (wq_n !== 1'b0);
    wr <= 0;
    rd <= 0;
  endtask

  // ********
  // clock, watcher and timeout
  // ********
  initial begin
    forever #20 clk = ~clk;
  end
  // negedge sampling keeps clear of the edge where inputs change
  always @(negedge clk) begin
    wq_n = wq;
    if (rd && wq === 1'b0) chk(rdat[7:0], exq.pop_front());
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  // ********
  // main sequence
  // ********
  initial begin
    void'($urandom(32'h5ba5ffd8));
    repeat (6) @(posedge clk);
    rst <= 0;
    r = '{PPC_PA_PU_RST, PPC_OD_RST, PPC_PB_PU_RST, PPC_OD_RST};
    for (int k = 0; k < 4; k++) bus(0, ad[k], r[k]);
    bus(0, 4'h2, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 24; i++) begin
      for (int k = 0; k < 4; k++) begin
        v = $urandom;
        r[k] = v[7:0] & mk[k];
        bus(1, ad[k], v[7:0]);
        bus(0, ad[k], r[k]);
      end
      v = $urandom;
      w = $urandom;
      x = $urandom;
      @(posedge clk);
      {da, la, db, lb} <= v;
      {lc, dc, an, rs} <= w;
      ro <= x[7:0];
      gdis <= x[8] & x[9];
      extr <= x[10];
      @(posedge clk);
      @(negedge clk);
      xa = (r[0] & ~da & {8{~gdis}}) | {4'h0, extr, 3'h0};
      chk(pa, xa);
      chk(pb, r[2] & ~db & {8{~gdis}});
      chk(ea, da & ~(r[1] & la));
      chk(oa, la);
      chk(eb, db & ~(r[3] & lb));
      chk(ob, lb);
      xc = (rs & ro) | (~rs & lc);
      ee = dc | rs;
      chk(oc, xc);
      chk(ec, ee);
      chk(dic, ((ee & xc) | (~ee & ~xc)) & ~an);
      chk(aac, an);
    end
    $display("test random pad control done");
    end_sim();
  end
endmodule
